// ===== include/scfs_cfg.svh
// timing counts, register offsets and field positions of the fault supervisor
`ifndef SCFS_CFG_SVH
`define SCFS_CFG_SVH
`define SCFS_CLK_NS 10
`define SCFS_TICK_NS 1000000
`define SCFS_TICK_CYCLES (`SCFS_TICK_NS / `SCFS_CLK_NS)
`define SCFS_MS_TICKS(ms) (((ms) * 1000000) / `SCFS_TICK_NS)
`define SCFS_RF_ON_MS 1350
`define SCFS_RF_OFF_MS 850
`define SCFS_WD_ON_MS 1000
`define SCFS_WD_OFF_MS 1500
`define SCFS_BO_ON_MS 400
`define SCFS_BO_ALT_MS 400
`define SCFS_SF_MS 550
`define SCFS_SF_UNDEF_MS 250
`define SCFS_NCH 18
`define SCFS_CW 12
`define SCFS_ADDR_STATUS 8'h00
`define SCFS_ADDR_MASK 8'h04
`define SCFS_ADDR_CTRL 8'h08
`define SCFS_ADDR_CHAN 8'h0C
`define SCFS_CTRL_RESET 0
`define SCFS_ST_CARD 0
`define SCFS_ST_CABLE 1
`define SCFS_ST_REDF 2
`define SCFS_ST_WDOG 3
`define SCFS_ST_CONF 4
`define SCFS_ST_BROWN 5
`define SCFS_ST_W 6
`define SCFS_STATUS_RST 6'h00
`define SCFS_MASK_RST 6'h00
`endif

// ===== include/scfs_pkg.sv
// types shared by the fault supervisor files
`default_nettype none
package scfs_pkg;
    typedef enum logic [0:0] {
        SCFS_MON,
        SCFS_TRIG
    } scfs_mode_t;
    typedef logic [5:0] scfs_stat_t;
endpackage
`default_nettype wire

// ===== logic/scfs_ptimer.sv
// persistence timer: counts ticks while run is high, flags expiry
`timescale 1ns/100ps
`default_nettype none
module scfs_ptimer #(
    parameter int CW = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic tick,
    input wire logic run,
    input wire logic [CW-1:0] limit,
    output logic expired
);
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic expired_reg;
    logic expired_next;

    // restart whenever the condition drops, saturate once expired
    always_comb begin
        count_next = count_reg;
        expired_next = expired_reg;
        if (!run) begin
            count_next = '0;
            expired_next = 1'b0;
        end else if (tick && !expired_reg) begin
            count_next = count_reg + 1'b1;
            expired_next = (count_reg + 1'b1) >= limit;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            expired_reg <= 1'b0;
        end else if (ce) begin
            count_reg <= count_next;
            expired_reg <= expired_next;
        end
    end

    assign expired = expired_reg;

    // a dropped condition always clears the timer
    tmr_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && !run |=> !expired_reg && count_reg == '0) // [RULE_16]
        else $error("timer did not restart");
endmodule // scfs_ptimer
`default_nettype wire

// ===== logic/scfs_supervisor.sv
// fault supervisor core of the eighteen channel conflict monitor
//
// Overview of operation
// [RULE_01] Eighteen channels, each with green, yellow and red qualified inputs.
// [RULE_02] Missing compatibility card triggers; stays until card back and reset.
// [RULE_03] Fault captures active or failed channels and holds them until reset.
// [RULE_04] Timing switch picks red failure time: on 1350 ms, off 850 ms.
// [RULE_05] Select switch picks watchdog time: on 1.0 s, off 1.5 s.
// [RULE_06] Line-level option on: drop-out lasting 400 ms counts as brown-out.
// [RULE_07] Watchdog latch off: power event clears a pending watchdog fault.
// [RULE_08] Watchdog latch on: watchdog fault holds until explicit reset command.
// [RULE_09] Polarity option inverts output relay common sense, low then active.
// [RULE_10] Red interface cable disconnected raises latching fault and forces flash.
// [RULE_11] Active special function input suppresses red failure monitoring only.
// [RULE_12] Special function input active only after 550 ms continuous high.
// [RULE_13] Special function high 250 to 550 ms may read either way.
// [RULE_14] Red failure needs red enable, no special function, relay common inactive.
// [RULE_15] Brown-out time with line-level option off comes from a parameter.
// [RULE_16] All fault timers count a fixed tick derived from the system clock.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "scfs_cfg.svh"
module scfs_supervisor #(
    parameter int NCH = `SCFS_NCH,
    parameter int CW = `SCFS_CW,
    parameter int TICK_CYCLES = `SCFS_TICK_CYCLES,
    parameter logic [CW-1:0] BO_ALT_TICKS = CW'(`SCFS_MS_TICKS(`SCFS_BO_ALT_MS))
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [NCH-1:0] green_in,
    input wire logic [NCH-1:0] yellow_in,
    input wire logic [NCH-1:0] red_in,
    input wire logic [NCH-1:0] red_fail_en,
    input wire logic red_enable_in,
    input wire logic sf1_in,
    input wire logic sf2_in,
    input wire logic output_relay_common_in,
    input wire logic relay_common_invert,
    input wire logic card_present_in,
    input wire logic red_interface_cable,
    input wire logic watchdog_in,
    input wire logic rf_time_sel,
    input wire logic wd_time_sel,
    input wire logic line_level_opt,
    input wire logic line_drop_in,
    input wire logic power_restore_in,
    input wire logic wd_latch_en,
    input wire logic conflict_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic flash_out,
    output logic compat_card_missing_flag,
    output logic watchdog_fault_flag,
    output logic cable_fault_flag,
    output logic red_fail_flag,
    output logic conflict_flag,
    output logic [NCH-1:0] chan_ind,
    output logic [NCH-1:0] snap_green,
    output logic [NCH-1:0] snap_yellow,
    output logic [NCH-1:0] snap_red
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    // tick generator
    logic [TW-1:0] tick_cnt_reg;
    logic [TW-1:0] tick_cnt_next;
    logic tick_reg;
    logic tick_next;

    // one tick per millisecond keeps every timer within its tolerance
    always_comb begin
        tick_next = (tick_cnt_reg == TICK_LAST); // [RULE_16]
        tick_cnt_next = tick_next ? '0 : tick_cnt_reg + 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // timer limits, all but the fixed special function limit picked by the option switches
    logic [CW-1:0] rf_lim;
    logic [CW-1:0] wd_lim;
    logic [CW-1:0] bo_lim;
    logic [CW-1:0] sf_lim;
    assign rf_lim = rf_time_sel ? CW'(`SCFS_MS_TICKS(`SCFS_RF_ON_MS)) :
        CW'(`SCFS_MS_TICKS(`SCFS_RF_OFF_MS)); // [RULE_04]
    assign wd_lim = wd_time_sel ? CW'(`SCFS_MS_TICKS(`SCFS_WD_ON_MS)) :
        CW'(`SCFS_MS_TICKS(`SCFS_WD_OFF_MS)); // [RULE_05]
    assign bo_lim = line_level_opt ? CW'(`SCFS_MS_TICKS(`SCFS_BO_ON_MS)) :
        BO_ALT_TICKS; // [RULE_06] [RULE_15]
    // the undefined band below 550 ms is resolved as not active
    assign sf_lim = CW'(`SCFS_MS_TICKS(`SCFS_SF_MS)); // [RULE_12] [RULE_13]

    // qualification of the relay common and special function inputs
    logic relay_active;
    logic sf1_done;
    logic sf2_done;
    logic sf_active;
    logic wd_prev_reg;
    logic wd_run;
    logic wd_done;
    logic bo_done;
    logic bo_prev_reg;
    logic bo_rise;
    logic power_event;
    logic [NCH-1:0] dark;
    logic [NCH-1:0] rf_run;
    logic [NCH-1:0] rf_done;
    assign relay_active = output_relay_common_in
        ^ relay_common_invert; // [RULE_09]
    assign sf_active = sf1_done | sf2_done;
    assign dark = ~(green_in | yellow_in | red_in); // [RULE_01]
    // red failure is only watched in the permitted conditions
    assign rf_run = red_fail_en & dark & {NCH{red_enable_in & !sf_active
        & !relay_active}}; // [RULE_11] [RULE_14]
    assign wd_run = !(watchdog_in ^ wd_prev_reg);
    assign bo_rise = bo_done & !bo_prev_reg;
    assign power_event = bo_rise | power_restore_in;

    scfs_ptimer #(.CW(CW)) u_sf1 (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(tick_reg),
        .run(sf1_in), .limit(sf_lim), .expired(sf1_done)
    );
    scfs_ptimer #(.CW(CW)) u_sf2 (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(tick_reg),
        .run(sf2_in), .limit(sf_lim), .expired(sf2_done)
    );
    scfs_ptimer #(.CW(CW)) u_wd (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(tick_reg),
        .run(wd_run), .limit(wd_lim), .expired(wd_done)
    );
    scfs_ptimer #(.CW(CW)) u_bo (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(tick_reg),
        .run(line_drop_in), .limit(bo_lim), .expired(bo_done)
    );

    // one red failure timer per channel
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_rf
            scfs_ptimer #(.CW(CW)) u_rf (
                .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(tick_reg),
                .run(rf_run[gi]), .limit(rf_lim), .expired(rf_done[gi])
            );
        end
    endgenerate

    // register port decode
    logic reset_cmd;
    logic [`SCFS_ST_W-1:0] w1c;
    logic [`SCFS_ST_W-1:0] mask_reg;
    logic [`SCFS_ST_W-1:0] mask_next;
    logic [`SCFS_ST_W-1:0] status_reg;
    logic [`SCFS_ST_W-1:0] status_next;
    logic [`SCFS_ST_W-1:0] ev;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic irq_reg;
    logic irq_next;
    assign reset_cmd = reset_in | (reg_wr && reg_addr == `SCFS_ADDR_CTRL
        && reg_wdata[`SCFS_CTRL_RESET]);
    assign w1c = (reg_wr && reg_addr == `SCFS_ADDR_STATUS) ?
        reg_wdata[`SCFS_ST_W-1:0] : '0;

    // fault latches and channel capture
    scfs_pkg::scfs_mode_t mode_reg;
    scfs_pkg::scfs_mode_t mode_next;
    logic card_reg, card_next;
    logic cable_reg, cable_next;
    logic rf_reg, rf_next;
    logic wd_reg, wd_next;
    logic conf_reg, conf_next;
    logic any_next;
    logic flash_reg;
    logic [NCH-1:0] chan_reg, chan_next;
    logic [NCH-1:0] sg_reg, sg_next;
    logic [NCH-1:0] sy_reg, sy_next;
    logic [NCH-1:0] sr_reg, sr_next;

    always_comb begin
        card_next = !card_present_in
            | (card_reg & !(reset_cmd & card_present_in)); // [RULE_02]
        cable_next = !red_interface_cable | (cable_reg & !reset_cmd); // [RULE_10]
        rf_next = (|rf_done) | (rf_reg & !reset_cmd);
        conf_next = conflict_in | (conf_reg & !reset_cmd);
        // a new expiry wins over any clearing in the same cycle
        wd_next = wd_done | (wd_reg & !reset_cmd
            & !(power_event & !wd_latch_en)); // [RULE_07] [RULE_08]
        any_next = card_next | cable_next | rf_next | wd_next | conf_next;
        mode_next = mode_reg;
        chan_next = chan_reg;
        sg_next = sg_reg;
        sy_next = sy_reg;
        sr_next = sr_reg;
        unique case (mode_reg)
            scfs_pkg::SCFS_MON: begin
                if (any_next) begin
                    mode_next = scfs_pkg::SCFS_TRIG;
                    chan_next = conflict_in ? (green_in | yellow_in) :
                        rf_done; // [RULE_03]
                    sg_next = green_in;
                    sy_next = yellow_in;
                    sr_next = red_in;
                end
            end
            scfs_pkg::SCFS_TRIG: begin
                if (!any_next) begin
                    mode_next = scfs_pkg::SCFS_MON;
                    chan_next = '0;
                    sg_next = '0;
                    sy_next = '0;
                    sr_next = '0;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= scfs_pkg::SCFS_MON;
            card_reg <= 1'b0;
            cable_reg <= 1'b0;
            rf_reg <= 1'b0;
            wd_reg <= 1'b0;
            conf_reg <= 1'b0;
            flash_reg <= 1'b0;
            chan_reg <= '0;
            sg_reg <= '0;
            sy_reg <= '0;
            sr_reg <= '0;
            wd_prev_reg <= 1'b0;
            bo_prev_reg <= 1'b0;
        end else if (ce) begin
            mode_reg <= mode_next;
            card_reg <= card_next;
            cable_reg <= cable_next;
            rf_reg <= rf_next;
            wd_reg <= wd_next;
            conf_reg <= conf_next;
            flash_reg <= any_next;
            chan_reg <= chan_next;
            sg_reg <= sg_next;
            sy_reg <= sy_next;
            sr_reg <= sr_next;
            wd_prev_reg <= watchdog_in;
            bo_prev_reg <= bo_done;
        end
    end

    // sticky status, mask, interrupt and read data
    always_comb begin
        ev = '0;
        ev[`SCFS_ST_CARD] = card_next & !card_reg;
        ev[`SCFS_ST_CABLE] = cable_next & !cable_reg;
        ev[`SCFS_ST_REDF] = rf_next & !rf_reg;
        ev[`SCFS_ST_WDOG] = wd_next & !wd_reg;
        ev[`SCFS_ST_CONF] = conf_next & !conf_reg;
        ev[`SCFS_ST_BROWN] = bo_rise;
        status_next = (status_reg & ~w1c) | ev; // set wins over clear
        mask_next = (reg_wr && reg_addr == `SCFS_ADDR_MASK) ?
            reg_wdata[`SCFS_ST_W-1:0] : mask_reg;
        irq_next = |(status_next & mask_next);
        rdata_next = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `SCFS_ADDR_STATUS: rdata_next = {26'h0, status_reg};
                `SCFS_ADDR_MASK: rdata_next = {26'h0, mask_reg};
                `SCFS_ADDR_CTRL: rdata_next = {31'h0, flash_reg};
                `SCFS_ADDR_CHAN: rdata_next = 32'(chan_reg);
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= `SCFS_STATUS_RST;
            mask_reg <= `SCFS_MASK_RST;
            irq_reg <= 1'b0;
            rdata_reg <= '0;
        end else if (ce) begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;
    assign flash_out = flash_reg;
    assign compat_card_missing_flag = card_reg;
    assign watchdog_fault_flag = wd_reg;
    assign cable_fault_flag = cable_reg;
    assign red_fail_flag = rf_reg;
    assign conflict_flag = conf_reg;
    assign chan_ind = chan_reg;
    assign snap_green = sg_reg;
    assign snap_yellow = sy_reg;
    assign snap_red = sr_reg;

    // checks on the fault latches, red failure suppression and interrupt
    card_trip_a: assert property (ce && !card_present_in |=> card_reg) // [RULE_02]
        else $error("missing card did not trigger");
    card_hold_a: assert property (card_reg && ce
        && !(reset_cmd && card_present_in) |=> card_reg) // [RULE_02]
        else $error("card fault dropped without reset");
    cable_flash_a: assert property (ce && !red_interface_cable
        |=> cable_reg && flash_reg) // [RULE_10]
        else $error("cable loss did not force flash");
    sf_suppress_a: assert property (sf_active |-> rf_run == '0) // [RULE_11]
        else $error("red failure watched during special function");
    relay_pol_a: assert property ((output_relay_common_in != relay_common_invert)
        |-> rf_run == '0) // [RULE_09]
        else $error("red failure watched with relay common active");
    wd_latch_a: assert property (ce && wd_reg && wd_latch_en && !reset_cmd
        |=> wd_reg) // [RULE_08]
        else $error("latched watchdog fault lost");
    wd_power_clear_a: assert property (ce && wd_reg && !wd_latch_en
        && power_event && !wd_done |=> !wd_reg) // [RULE_07]
        else $error("watchdog fault not cleared by power event");
    chan_hold_a: assert property (ce && mode_reg == scfs_pkg::SCFS_TRIG
        && any_next |=> $stable(chan_reg) && $stable(sr_reg)) // [RULE_03]
        else $error("channel indication changed while triggered");
    irq_level_a: assert property (irq_reg == |(status_reg & mask_reg))
        else $error("interrupt does not follow masked status");
endmodule // scfs_supervisor
`default_nettype wire

// ===== tb/scfs_field_model.sv
// cabinet side model: controller watchdog and special function source
`timescale 1ns/100ps
`default_nettype none
module scfs_field_model (
    input wire logic mclk,
    input wire logic wd_run,
    input wire logic sf_chop,
    output logic watchdog_in,
    output logic sf1_in
);
    int cnt = 0;
    initial begin
        watchdog_in = 1'b0;
        sf1_in = 1'b0;
    end
    // watchdog toggles every 8 cycles; chopped input stays under 250 ticks
    always @(posedge mclk) begin
        cnt <= cnt + 1;
        if (wd_run && (cnt % 8 == 0)) begin
            watchdog_in <= !watchdog_in;
        end
        sf1_in <= sf_chop && (cnt % 968 < 960);
    end
endmodule // scfs_field_model
`default_nettype wire

// ===== tb/scfs_supervisor_bench.sv
// self-checking bench for the fault supervisor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end end
module scfs_supervisor_bench;
    logic mclk = 0, rst_n = 0, ce = 1, red_enable_in = 1, sf2_in = 0;
    logic output_relay_common_in = 0, relay_common_invert = 0;
    logic card_present_in = 1, red_interface_cable = 1, rf_time_sel = 0;
    logic wd_time_sel = 0, line_level_opt = 1, line_drop_in = 0;
    logic power_restore_in = 0, wd_latch_en = 0, conflict_in = 0;
    logic reset_in = 0, reg_wr = 0, reg_rd = 0, wd_run = 1, sf_chop = 0;
    logic [17:0] green_in = '0, yellow_in = '0, red_in = '1;
    logic [17:0] red_fail_en = '1, chan_ind, snap_green, snap_yellow;
    logic [17:0] snap_red;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, rv;
    logic irq, flash_out, compat_card_missing_flag, watchdog_fault_flag;
    logic cable_fault_flag, red_fail_flag, conflict_flag, watchdog_in, sf1_in;
    logic [5:0] fl;
    int err_total = 0, cmp_count = 0;
    // flag bundle: card, cable, red fail, watchdog, conflict, irq
    assign fl = {irq, conflict_flag, watchdog_fault_flag, red_fail_flag,
        cable_fault_flag, compat_card_missing_flag};
    always #5 mclk = ~mclk;
    // one tick every four clocks keeps the long fault times short
    scfs_supervisor #(.TICK_CYCLES(4), .BO_ALT_TICKS(12'h064))
        scfs_supervisor_inst (.mclk, .rst_n, .ce, .green_in, .yellow_in,
        .red_in, .red_fail_en, .red_enable_in, .sf1_in, .sf2_in,
        .output_relay_common_in, .relay_common_invert, .card_present_in,
        .red_interface_cable, .watchdog_in, .rf_time_sel, .wd_time_sel,
        .line_level_opt, .line_drop_in, .power_restore_in, .wd_latch_en,
        .conflict_in, .reset_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .flash_out, .compat_card_missing_flag,
        .watchdog_fault_flag, .cable_fault_flag, .red_fail_flag,
        .conflict_flag, .chan_ind, .snap_green, .snap_yellow, .snap_red);
    scfs_field_model scfs_field_model_inst (.mclk, .wd_run, .sf_chop,
        .watchdog_in, .sf1_in);
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        cyc(1);
        reg_wr <= 0;
        cyc(1);
    endtask
    // read data is seen at the edge closing the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1;
        cyc(1);
        reg_rd <= 0;
        cyc(1);
        rv = reg_rdata;
    endtask
    task automatic meas(input int b, input int lo, input int hi);
        int n;
        n = 0;
        while (fl[b] !== 1'b1) begin
            cyc(1);
            n++;
            if (n > hi) begin
                err_total++;
                $display("[FAIL] wait on flag %0d ran out", b);
                end_sim;
            end
        end
        `CHK("fault delay", 1'b1, n >= lo)
    endtask
    task automatic quiet(input int b, input int n);
        logic seen;
        seen = 0;
        repeat (n) begin
            cyc(1);
            seen |= fl[b];
        end
        `CHK("no fault", 1'b0, seen)
    endtask
    // front panel reset plus status clear, then all flags must be low
    task automatic clr;
        cyc(2); // let a timer that just expired fall idle first
        reset_in <= 1;
        cyc(1);
        reset_in <= 0;
        wr(8'h00, 32'h3F);
        cyc(3);
        `CHK("cleared", 6'h00, fl)
    endtask
    task automatic t_regs;
        for (int a = 0; a <= 16; a += 4) begin
            rd(8'(a));
            `CHK("reset reg", 32'h0, rv)
        end
    endtask
    task automatic t_card;
        wr(8'h04, 32'h3F);
        ce <= 0;
        card_present_in <= 0;
        cyc(4);
        `CHK("frozen", 1'b0, compat_card_missing_flag)
        ce <= 1;
        cyc(2);
        // the flag and flash latch at the same edge
        `CHK("card", 2'b11, {flash_out, compat_card_missing_flag})
        cyc(1);
        `CHK("card flash", 2'b11, {flash_out, irq})
        rd(8'h00);
        `CHK("status", 32'h1, rv)
        rd(8'h08);
        `CHK("ctrl", 32'h1, rv)
        wr(8'h08, 32'h1);
        cyc(2);
        `CHK("card held", 1'b1, compat_card_missing_flag)
        card_present_in <= 1;
        clr;
    endtask
    task automatic t_cable;
        red_interface_cable <= 0;
        cyc(3);
        `CHK("cable", 2'b11, {flash_out, cable_fault_flag})
        red_interface_cable <= 1;
        cyc(4);
        `CHK("cable held", 1'b1, cable_fault_flag)
        // a reset command written over the register port also clears it
        wr(8'h08, 32'h1);
        `CHK("cable cmd", 2'b00, {flash_out, cable_fault_flag})
        clr;
    endtask
    task automatic t_redfail;
        int ms;
        for (int s = 0; s < 2; s++) begin
            ms = s ? 1350 : 850;
            rf_time_sel <= s[0];
            red_in <= 18'h3FFFE;
            meas(2, ms * 4 - 4, ms * 4 + 12);
            `CHK("chan", 18'h00001, chan_ind)
            `CHK("snap", 18'h3FFFE, snap_red)
            rd(8'h0C);
            `CHK("chan reg", 32'h1, rv)
            red_in <= '1;
            clr;
        end
        rf_time_sel <= 0;
    endtask
    // enable off, relay common active, special function held: no red fail
    task automatic t_suppress;
        for (int i = 0; i < 3; i++) begin
            red_enable_in <= (i != 0);
            relay_common_invert <= (i == 1);
            sf2_in <= (i == 2);
            cyc(2400);
            red_in <= 18'h3FFFE;
            quiet(2, 4000);
            red_in <= '1;
        end
        conflict_in <= 1;
        green_in <= 18'h00028;
        yellow_in <= 18'h00100;
        cyc(3);
        `CHK("conflict", 1'b1, conflict_flag)
        `CHK("conf chan", 18'h00128, chan_ind)
        `CHK("snap grn", 18'h00028, snap_green)
        `CHK("snap yel", 18'h00100, snap_yellow)
        conflict_in <= 0;
        green_in <= '0;
        yellow_in <= '0;
        sf2_in <= 0;
        clr;
        // inverted sense: a high relay common now reads as not active
        relay_common_invert <= 1;
        output_relay_common_in <= 1;
        red_in <= 18'h3FFFE;
        meas(2, 3396, 3412);
        red_in <= '1;
        relay_common_invert <= 0;
        output_relay_common_in <= 0;
        clr;
        sf_chop <= 1;
        red_in <= 18'h3FFFE;
        meas(2, 3396, 3412);
        sf_chop <= 0;
        red_in <= '1;
        clr;
    endtask
    task automatic t_wdog;
        int ms;
        for (int s = 0; s < 2; s++) begin
            ms = s ? 1000 : 1500;
            wd_time_sel <= s[0];
            wd_latch_en <= s[0];
            wd_run <= 0;
            meas(3, ms * 4 - 12, ms * 4 + 12);
            wd_run <= 1;
            cyc(20);
            `CHK("wd held", 1'b1, watchdog_fault_flag)
            power_restore_in <= 1;
            cyc(1);
            power_restore_in <= 0;
            cyc(3);
            `CHK("wd power", s[0], watchdog_fault_flag)
            clr;
        end
    endtask
    task automatic t_brown;
        int t;
        wd_latch_en <= 0;
        wr(8'h04, 32'h20);
        for (int o = 1; o >= 0; o--) begin
            t = o ? 400 : 100;
            line_level_opt <= o[0];
            wd_run <= 0;
            meas(3, 3988, 4012);
            wd_run <= 1;
            cyc(20);
            line_drop_in <= 1;
            meas(5, t * 4 - 4, t * 4 + 12);
            cyc(3);
            `CHK("wd brown", 1'b0, watchdog_fault_flag)
            line_drop_in <= 0;
            clr;
        end
    endtask
    initial begin
        cyc(12);
        `CHK("in reset", 6'h00, fl)
        rst_n <= 1;
        cyc(2);
        t_regs;
        t_card;
        t_cable;
        t_redfail;
        t_suppress;
        t_wdog;
        t_brown;
        end_sim;
    end
endmodule // scfs_supervisor_bench
`default_nettype wire
